// *** hole_output_defines.vh ***
// constants for the beam area hole output block
`ifndef HOLE_OUTPUT_DEFINES_VH
`define HOLE_OUTPUT_DEFINES_VH

`define BEAM_COUNT 32
`define AREA_COUNT 32
`define BYTE_W 8
`define HALF_W 16
`define BEAM_IDX_W 6

// area parameter object, index 100
`define AREA_OBJ_INDEX 100
`define AREA_CFG_W 112
`define AREA_EN_POS 104
`define AREA_LOGIC_POS 96
`define AREA_START_POS 80
`define AREA_END_POS 64
`define AREA_ON_POS 48
`define AREA_OFF_POS 32

// pin settings object, index 80, and mask object, index 84
`define PIN_OBJ_INDEX 80
`define PIN_CFG_W 32
`define PIN_DIR_POS 24
`define PIN_POL_POS 16
`define PIN_FUNC_POS 0
`define MASK_OBJ_INDEX 84
`define MASK_POS 0
`define MASK_W 32

// alternative object dictionary locations
`define OD_AREA1_OBJ 16'h2170 // RULE18
`define OD_AREA1_SUB_FIRST 8'h01
`define OD_AREA1_SUB_LAST 8'h06
`define OD_PIN_OBJ 16'h2151
`define OD_PIN_DIR_SUB 8'h01
`define OD_PIN_POL_SUB 8'h03
`define OD_PIN_FUNC_SUB 8'h04
`define OD_MASK_OBJ 16'h2155
`define OD_MASK_SUB 8'h03

// field codes
`define AREA_ENABLED 8'h01
`define LOGIC_NORMAL 8'h00
`define START_FIRST_BLOCKED 16'hfffe
`define END_LAST_BLOCKED 16'hfffc
`define PIN_DIR_OUTPUT 8'h00
`define PIN_POL_NORMAL 8'h00
`define PIN_POL_INVERTED 8'h01
`define PIN_FUNC_AREAS 16'h0001

`endif

// *** blocked_bound_finder.v ***
// first and last blocked beam of one scan
`timescale 1ns/100ps
`include "hole_output_defines.vh"
module blocked_bound_finder (
  input wire [`BEAM_COUNT-1:0] i_beam_free,
  output reg [`HALF_W-1:0] o_first_blocked,
  output reg [`HALF_W-1:0] o_last_blocked,
  output reg o_any_blocked
);
  integer k;
  // beams are numbered from 1; a zero result means no beam is blocked
  always @* begin
    o_first_blocked = {`HALF_W{1'b0}};
    o_last_blocked = {`HALF_W{1'b0}};
    o_any_blocked = 1'b0;
    for (k = `BEAM_COUNT - 1; k >= 0; k = k - 1) begin
      if (!i_beam_free[k]) begin
        o_first_blocked = k[`HALF_W-1:0] + 16'h0001;
      end
    end
    for (k = 0; k < `BEAM_COUNT; k = k + 1) begin
      if (!i_beam_free[k]) begin
        o_last_blocked = k[`HALF_W-1:0] + 16'h0001;
        o_any_blocked = 1'b1;
      end
    end
  end
endmodule

// *** free_window_counter.v ***
// count of free beams between two inclusive bounds
`timescale 1ns/100ps
`include "hole_output_defines.vh"
module free_window_counter (
  input wire [`BEAM_COUNT-1:0] i_beam_free,
  input wire [`HALF_W-1:0] i_lower,
  input wire [`HALF_W-1:0] i_upper,
  output reg [`HALF_W-1:0] o_free_count
);
  integer k;
  reg [`HALF_W-1:0] beam_no;
  always @* begin
    o_free_count = {`HALF_W{1'b0}};
    beam_no = {`HALF_W{1'b0}};
    for (k = 0; k < `BEAM_COUNT; k = k + 1) begin
      beam_no = k[`HALF_W-1:0] + 16'h0001;
      // an inverted window simply counts nothing
      if (i_beam_free[k] && beam_no >= i_lower && beam_no <= i_upper) begin
        o_free_count = o_free_count + 16'h0001;
      end
    end
  end
endmodule

// *** beam_area_hole_output.v ***
// beam area evaluation and switching output for hole detection
//
// Functional notes
// RULE1: area enable equal to 1 evaluates the area and offers its result.
// RULE2: normal logic behaviour asserts the result on free beams.
// RULE3: first-blocked selection puts the lower bound at the first blocked beam.
// RULE4: last-blocked selection puts the upper bound at the last blocked beam.
// RULE5: start limit 65534 means the dynamic first-blocked selection.
// RULE6: end limit 65532 means the dynamic last-blocked selection.
// RULE7: an ordinary start limit is a fixed lower bound.
// RULE8: an ordinary end limit is a fixed upper bound.
// RULE9: switch-on threshold 1 switches on with one free beam in bounds.
// RULE10: separate switch-off threshold on free count gives hysteresis.
// RULE11: pin direction 0 drives pin 2 as an output.
// RULE12: output function 1 drives the pin from areas 1 to 32.
// RULE13: polarity 0 keeps the output level, polarity 1 inverts it.
// RULE14: output level is OR of area results selected by the 32-bit mask.
// RULE15: mask bit 0 selects area 01.
// RULE16: area object fields sit at bit offsets 104, 96, 80, 64, 48, 32.
// RULE17: pin object fields at 24, 16, 0; mask at offset 0 of index 84.
// RULE18: alternative dictionary objects hold the same fields.
// RULE19: the master configures an area before mapping it to the pin.
// RULE20: each scan counts free beams within bounds and updates the output.
`timescale 1ns/100ps
`include "hole_output_defines.vh"
module beam_area_hole_output (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_scan_valid,
  input wire [`BEAM_COUNT-1:0] i_beam_free,
  input wire [`AREA_CFG_W-1:0] i_area_cfg,
  input wire [`PIN_CFG_W-1:0] i_pin_cfg,
  input wire [`MASK_W-1:0] i_area_mask,
  input wire [`AREA_COUNT-1:1] i_other_area_result,
  input wire i_pin2,
  output reg o_pin2,
  output reg o_pin2_oe,
  output reg o_pin2_level,
  output reg o_area_result,
  output reg [`HALF_W-1:0] o_free_count,
  output reg [`HALF_W-1:0] o_lower_bound,
  output reg [`HALF_W-1:0] o_upper_bound,
  output reg o_web_present,
  output reg o_bound_error,
  output reg o_scan_done
);

  // decoding of one start or end limit, used for both bounds
  function [`HALF_W-1:0] resolve_bound;
    input [`HALF_W-1:0] raw;
    input [`HALF_W-1:0] dyn_code;
    input [`HALF_W-1:0] dyn_value;
    begin
      if (raw == dyn_code) begin
        resolve_bound = dyn_value;
      end else begin
        resolve_bound = raw;
      end
    end
  endfunction

  // a zero sense field passes the level, any other value inverts it
  function apply_sense;
    input level;
    input [`BYTE_W-1:0] sense;
    begin
      if (sense == 8'h00) begin
        apply_sense = level;
      end else begin
        apply_sense = ~level;
      end
    end
  endfunction

  // field extraction from the packed parameter objects
  wire [`BYTE_W-1:0] area_enable_field;
  wire [`BYTE_W-1:0] logic_field;
  wire [`HALF_W-1:0] start_field;
  wire [`HALF_W-1:0] end_field;
  wire [`HALF_W-1:0] on_thresh;
  wire [`HALF_W-1:0] off_thresh;
  wire [`BYTE_W-1:0] pin_dir_field;
  wire [`BYTE_W-1:0] pin_pol_field;
  wire [`HALF_W-1:0] pin_func_field;
  wire [`MASK_W-1:0] mask_field;

  assign area_enable_field = i_area_cfg[`AREA_EN_POS +: `BYTE_W]; // RULE16
  assign logic_field = i_area_cfg[`AREA_LOGIC_POS +: `BYTE_W]; // RULE16
  assign start_field = i_area_cfg[`AREA_START_POS +: `HALF_W]; // RULE16
  assign end_field = i_area_cfg[`AREA_END_POS +: `HALF_W]; // RULE16
  assign on_thresh = i_area_cfg[`AREA_ON_POS +: `HALF_W]; // RULE16
  assign off_thresh = i_area_cfg[`AREA_OFF_POS +: `HALF_W]; // RULE16
  assign pin_dir_field = i_pin_cfg[`PIN_DIR_POS +: `BYTE_W]; // RULE17
  assign pin_pol_field = i_pin_cfg[`PIN_POL_POS +: `BYTE_W]; // RULE17
  assign pin_func_field = i_pin_cfg[`PIN_FUNC_POS +: `HALF_W]; // RULE17
  assign mask_field = i_area_mask[`MASK_POS +: `MASK_W]; // RULE17

  // pin 2 read-back through two flip-flops
  // only the second flop is read; the first may still be settling
  reg pin2_meta;
  reg pin2_sync;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin2_meta <= 1'b0;
      pin2_sync <= 1'b0;
    end else begin
      pin2_meta <= i_pin2;
      pin2_sync <= pin2_meta;
    end
  end

  // stage one: capture the scan so the evaluation sees a stable pattern
  // a new scan is taken in any cycle with i_scan_valid, so scans may come back to back
  reg [`BEAM_COUNT-1:0] scan_beams;
  reg scan_pending;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scan_beams <= {`BEAM_COUNT{1'b1}};
      scan_pending <= 1'b0;
    end else begin
      scan_pending <= i_scan_valid;
      if (i_scan_valid) begin
        scan_beams <= i_beam_free;
      end
    end
  end

  // dynamic bounds of the captured scan
  wire [`HALF_W-1:0] first_blocked;
  wire [`HALF_W-1:0] last_blocked;
  wire any_blocked;

  blocked_bound_finder u_bound_finder (
    .i_beam_free(scan_beams),
    .o_first_blocked(first_blocked),
    .o_last_blocked(last_blocked),
    .o_any_blocked(any_blocked)
  );

  wire start_is_dynamic;
  wire end_is_dynamic;
  wire [`HALF_W-1:0] lower_bound;
  wire [`HALF_W-1:0] upper_bound;

  assign start_is_dynamic = (start_field == `START_FIRST_BLOCKED); // RULE5
  assign end_is_dynamic = (end_field == `END_LAST_BLOCKED); // RULE6
  // with no blocked beam both dynamic bounds read zero; a zero upper bound leaves the window empty
  assign lower_bound = resolve_bound(start_field, `START_FIRST_BLOCKED, first_blocked); // RULE3 RULE7
  assign upper_bound = resolve_bound(end_field, `END_LAST_BLOCKED, last_blocked); // RULE4 RULE8

  wire [`HALF_W-1:0] free_count;

  free_window_counter u_window_counter (
    .i_beam_free(scan_beams),
    .i_lower(lower_bound),
    .i_upper(upper_bound),
    .o_free_count(free_count)
  );

  // fixed bounds outside the curtain or reversed are flagged, not corrected
  wire start_out_of_range;
  wire end_out_of_range;
  wire bounds_reversed;
  wire fixed_bound_bad;

  assign start_out_of_range = !start_is_dynamic && (start_field == 16'h0000 || start_field > `BEAM_COUNT); // RULE7
  assign end_out_of_range = !end_is_dynamic && (end_field == 16'h0000 || end_field > `BEAM_COUNT); // RULE8
  // a reversed window still runs, it just counts nothing
  assign bounds_reversed = !start_is_dynamic && !end_is_dynamic && (start_field > end_field); // RULE7 RULE8
  assign fixed_bound_bad = start_out_of_range || end_out_of_range || bounds_reversed;

  // stage two: hysteresis on the free count
  wire area_enabled;
  reg area_state;
  reg next_area_state;
  reg [`HALF_W-1:0] free_count_q;
  reg [`HALF_W-1:0] lower_q;
  reg [`HALF_W-1:0] upper_q;
  reg web_present_q;
  reg bound_error_q;
  reg eval_done;

  assign area_enabled = (area_enable_field == `AREA_ENABLED); // RULE1

  // on wins over off when the two thresholds overlap
  always @* begin
    next_area_state = area_state;
    if (!area_enabled) begin
      next_area_state = 1'b0;
    end else if (free_count >= on_thresh) begin
      next_area_state = 1'b1; // RULE9
    end else if (free_count <= off_thresh) begin
      next_area_state = 1'b0; // RULE10
    end
  end

  // a disabled area drops at once, not at its next scan
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      area_state <= 1'b0;
    end else if (!area_enabled) begin
      area_state <= 1'b0; // RULE1
    end else if (scan_pending) begin
      area_state <= next_area_state; // RULE20
    end
  end

  // snapshot of the scan for the result outputs
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      free_count_q <= 16'h0000;
      lower_q <= 16'h0000;
      upper_q <= 16'h0000;
      web_present_q <= 1'b0;
      bound_error_q <= 1'b0;
      eval_done <= 1'b0;
    end else begin
      // the done pulse lines up with the registered results
      eval_done <= scan_pending;
      if (scan_pending) begin
        free_count_q <= free_count; // RULE20
        lower_q <= lower_bound; // RULE3 RULE7
        upper_q <= upper_bound; // RULE4 RULE8
        web_present_q <= any_blocked;
        bound_error_q <= fixed_bound_bad;
      end
    end
  end

  // logic behaviour: normal passes the free-beam state, anything else inverts
  wire area_logic;

  assign area_logic = area_enabled
    & apply_sense(area_state, logic_field); // RULE1 RULE2

  // mask gating of all 32 area results
  wire [`AREA_COUNT-1:0] all_areas;
  wire [`AREA_COUNT-1:0] gated_areas;

  assign all_areas = {i_other_area_result, area_logic}; // RULE15

  genvar g;
  generate
    for (g = 0; g < `AREA_COUNT; g = g + 1) begin : gen_mask
      assign gated_areas[g] = all_areas[g] & mask_field[g]; // RULE14
    end
  endgenerate

  wire mapped_level;
  wire function_is_areas;
  wire function_level;
  wire pin_level;
  wire pin_is_output;
  wire next_pin2;

  assign mapped_level = |gated_areas; // RULE14

  assign function_is_areas = (pin_func_field == `PIN_FUNC_AREAS); // RULE12
  // other output functions are not part of this block and give a low level ahead of the polarity
  assign function_level = function_is_areas ? mapped_level : 1'b0; // RULE12
  assign pin_level = apply_sense(function_level, pin_pol_field); // RULE13

  // direction decides both the enable and the parked value
  assign pin_is_output = (pin_dir_field == `PIN_DIR_OUTPUT); // RULE11
  assign next_pin2 = pin_is_output ? pin_level : 1'b0; // RULE11 RULE13

  // stage three: every output from a flip-flop
  // pin, mask, logic and disable changes reach the pin within one cycle; thresholds and bounds wait for a scan, scans after three
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin2 <= 1'b0;
      o_pin2_oe <= 1'b0;
      o_pin2_level <= 1'b0;
      o_area_result <= 1'b0;
    end else begin
      o_pin2 <= next_pin2; // RULE11 RULE13
      o_pin2_oe <= pin_is_output; // RULE11
      o_pin2_level <= pin2_sync;
      o_area_result <= area_logic; // RULE1
    end
  end

  // scan results stand until the next scan replaces them
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_free_count <= 16'h0000;
      o_lower_bound <= 16'h0000;
      o_upper_bound <= 16'h0000;
      o_web_present <= 1'b0;
      o_bound_error <= 1'b0;
      o_scan_done <= 1'b0;
    end else begin
      o_free_count <= free_count_q;
      o_lower_bound <= lower_q;
      o_upper_bound <= upper_q;
      o_web_present <= web_present_q;
      o_bound_error <= bound_error_q;
      o_scan_done <= eval_done; // RULE20
    end
  end

endmodule

// *** beam_area_hole_output_checker.sv ***
// assertions on the ports of the hole output block
`timescale 1ns/100ps
module beam_area_hole_output_checker (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_scan_valid,
  input wire [31:0] i_beam_free,
  input wire [111:0] i_area_cfg,
  input wire [31:0] i_pin_cfg,
  input wire [31:0] i_area_mask,
  input wire [31:1] i_other_area_result,
  input wire o_pin2,
  input wire o_pin2_oe,
  input wire o_area_result,
  input wire [15:0] o_free_count,
  input wire [15:0] o_lower_bound,
  input wire [15:0] o_upper_bound,
  input wire o_web_present,
  input wire o_scan_done
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire en = i_area_cfg[111:104] == 8'h01;
  wire norm = en && i_area_cfg[103:96] == 8'h00;
  wire [15:0] on_thr = i_area_cfg[63:48];
  property p_done; i_scan_valid |-> ##3 o_scan_done; endproperty
  a_done: assert property (p_done) else $error("scan result late");
  property p_pulse; o_scan_done |-> $past(i_scan_valid, 3); endproperty
  a_pulse: assert property (p_pulse) else $error("result without scan");
  property p_oe; 1 |=> o_pin2_oe == ($past(i_pin_cfg[31:24]) == 8'h00); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_undriven; !o_pin2_oe |-> !o_pin2; endproperty
  a_undriven: assert property (p_undriven) else $error("pin value while undriven");
  // config must sit still long enough for area state and result to agree
  property p_pin;
    o_pin2_oe && $stable(i_pin_cfg) && $stable(i_area_mask) && $stable(i_other_area_result)
      && $stable(i_area_cfg) && $past(i_area_cfg, 2) == i_area_cfg
      |-> o_pin2 == ((i_pin_cfg[15:0] == 16'h0001 && |({i_other_area_result, o_area_result} & i_area_mask))
      ^ (i_pin_cfg[23:16] != 8'h00));
  endproperty
  a_pin: assert property (p_pin) else $error("pin level wrong");
  property p_web; o_scan_done |-> o_web_present == !(&$past(i_beam_free, 3)); endproperty
  a_web: assert property (p_web) else $error("web flag wrong");
  property p_first;
    o_scan_done && o_web_present && i_area_cfg[95:80] == 16'hfffe
      |-> (($past(i_beam_free, 3) >> (o_lower_bound - 16'h0001)) & 32'h0000_0001) == 32'h0000_0000;
  endproperty
  a_first: assert property (p_first) else $error("lower bound not blocked");
  property p_last;
    o_scan_done && o_web_present && i_area_cfg[79:64] == 16'hfffc
      |-> (($past(i_beam_free, 3) >> (o_upper_bound - 16'h0001)) & 32'h0000_0001) == 32'h0000_0000;
  endproperty
  a_last: assert property (p_last) else $error("upper bound not blocked");
  property p_on; o_scan_done && norm && o_free_count >= on_thr |-> o_area_result; endproperty
  a_on: assert property (p_on) else $error("area not on");
  property p_off;
    o_scan_done && norm && o_free_count < on_thr && o_free_count <= i_area_cfg[47:32] |-> !o_area_result;
  endproperty
  a_off: assert property (p_off) else $error("area not off");
  property p_dis; o_scan_done && !en && $stable(i_area_cfg) |-> !o_area_result; endproperty
  a_dis: assert property (p_dis) else $error("disabled area on");
endmodule
bind beam_area_hole_output beam_area_hole_output_checker u_chk (.i_clk_sys, .i_rst_n, .i_scan_valid,
  .i_beam_free, .i_area_cfg, .i_pin_cfg, .i_area_mask, .i_other_area_result, .o_pin2, .o_pin2_oe,
  .o_area_result, .o_free_count, .o_lower_bound, .o_upper_bound, .o_web_present, .o_scan_done);

// *** pin2_line.sv ***
// pin 2 line with pull-down, as the reading controller sees it
`timescale 1ns/100ps
module pin2_line (
  input wire i_drive,
  input wire i_drive_oe,
  output wire o_level
);
  // released line falls to the pull-down, never keeps the last value
  assign o_level = i_drive_oe ? i_drive : 1'b0;
endmodule

// *** beam_area_hole_output_tb_top.sv ***
// self-checking bench for the hole output block
`timescale 1ns/100ps
module beam_area_hole_output_tb_top;
  reg i_clk_sys = 0;
  reg i_rst_n = 0;
  reg i_scan_valid = 0;
  reg [31:0] i_beam_free = 32'hffff_ffff;
  reg [111:0] i_area_cfg = 112'h0;
  reg [31:0] i_pin_cfg = 32'h0000_0001;
  reg [31:0] i_area_mask = 32'h0;
  reg [31:1] i_other_area_result = 31'h0;
  wire o_pin2, o_pin2_oe, o_pin2_level, o_area_result, o_web_present, o_bound_error, o_scan_done, pin_wire;
  wire [15:0] o_free_count, o_lower_bound, o_upper_bound;
  integer err_count = 0;
  integer check_count = 0;
  beam_area_hole_output DUT (.i_clk_sys, .i_rst_n, .i_scan_valid, .i_beam_free, .i_area_cfg, .i_pin_cfg,
    .i_area_mask, .i_other_area_result, .i_pin2(pin_wire), .o_pin2, .o_pin2_oe, .o_pin2_level,
    .o_area_result, .o_free_count, .o_lower_bound, .o_upper_bound, .o_web_present, .o_bound_error,
    .o_scan_done);
  pin2_line u_line (.i_drive(o_pin2), .i_drive_oe(o_pin2_oe), .o_level(pin_wire));
  initial begin
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task area(input [7:0] en, input [7:0] lg, input [15:0] lo, input [15:0] hi, input [15:0] on, input [15:0] off);
    begin
      @(posedge i_clk_sys) #1 i_area_cfg = {en, lg, lo, hi, on, off, 32'h0000_0000};
      repeat (3) @(posedge i_clk_sys);
    end
  endtask
  task pin(input [7:0] dir, input [7:0] pol, input [15:0] func, input [31:0] mask);
    begin
      @(posedge i_clk_sys) #1 i_pin_cfg = {dir, pol, func};
      i_area_mask = mask;
      repeat (2) @(posedge i_clk_sys) #1;
    end
  endtask
  task scan(input [31:0] beam, input r, input [15:0] n, input [15:0] lo, input [15:0] hi, input p);
    integer k;
    begin
      @(posedge i_clk_sys) #1 i_scan_valid = 1;
      i_beam_free = beam;
      @(posedge i_clk_sys) #1 i_scan_valid = 0;
      // stale beams after the scan must not leak in
      i_beam_free = ~beam;
      k = 0;
      while (o_scan_done !== 1'b1 && k < 8) begin
        @(posedge i_clk_sys) #1 k = k + 1;
      end
      chk(o_scan_done, 16'h0001);
      chk({o_area_result, o_pin2}, {r, p});
      chk(o_free_count, n);
      chk(o_lower_bound, lo);
      chk(o_upper_bound, hi);
    end
  endtask
  initial begin
    repeat (16) @(posedge i_clk_sys);
    #1 i_rst_n = 1;
    area(8'h01, 8'h00, 16'hfffe, 16'hfffc, 16'h0001, 16'h0000);
    pin(8'h00, 8'h00, 16'h0001, 32'h0000_0001);
    chk(o_pin2_oe, 16'h0001);
    scan(32'hfff0_020f, 1, 16'h0001, 16'h0005, 16'h0014, 1);
    chk(o_web_present, 16'h0001);
    scan(32'hfff0_000f, 0, 16'h0000, 16'h0005, 16'h0014, 0);
    scan(32'hffff_ffff, 0, 16'h0000, 16'h0000, 16'h0000, 0);
    chk(o_web_present, 16'h0000);
    area(8'h01, 8'h00, 16'h0003, 16'h000a, 16'h0004, 16'h0002);
    scan(32'hffff_fc7f, 1, 16'h0005, 16'h0003, 16'h000a, 1);
    scan(32'hffff_fc1f, 1, 16'h0003, 16'h0003, 16'h000a, 1);
    scan(32'hffff_fe07, 0, 16'h0002, 16'h0003, 16'h000a, 0);
    scan(32'hffff_fc1f, 0, 16'h0003, 16'h0003, 16'h000a, 0);
    pin(8'h00, 8'h01, 16'h0001, 32'h0000_0001);
    scan(32'hffff_fc7f, 1, 16'h0005, 16'h0003, 16'h000a, 0);
    area(8'h01, 8'h01, 16'h0003, 16'h000a, 16'h0004, 16'h0002);
    scan(32'hffff_fc7f, 0, 16'h0005, 16'h0003, 16'h000a, 1);
    area(8'h00, 8'h00, 16'h0003, 16'h000a, 16'h0004, 16'h0002);
    scan(32'hffff_fc7f, 0, 16'h0005, 16'h0003, 16'h000a, 1);
    area(8'h01, 8'h00, 16'h000a, 16'h0003, 16'h0004, 16'h0002);
    scan(32'hffff_fc7f, 0, 16'h0000, 16'h000a, 16'h0003, 1);
    chk(o_bound_error, 16'h0001);
    area(8'h01, 8'h00, 16'h0003, 16'h000a, 16'h0004, 16'h0002);
    pin(8'h00, 8'h00, 16'h0001, 32'h0000_0000);
    scan(32'hffff_fc7f, 1, 16'h0005, 16'h0003, 16'h000a, 0);
    chk(o_bound_error, 16'h0000);
    @(posedge i_clk_sys) #1 i_other_area_result = 31'h0000_0040;
    pin(8'h00, 8'h00, 16'h0001, 32'h0000_0080);
    chk(o_pin2, 16'h0001);
    repeat (3) @(posedge i_clk_sys) #1;
    chk(o_pin2_level, 16'h0001);
    pin(8'h00, 8'h00, 16'h0000, 32'h0000_0080);
    chk(o_pin2, 16'h0000);
    pin(8'h01, 8'h01, 16'h0001, 32'h0000_0080);
    chk({o_pin2_oe, o_pin2}, 16'h0000);
    repeat (3) @(posedge i_clk_sys) #1;
    chk(o_pin2_level, 16'h0000);
    test_done;
  end
  initial begin
    #20000;
    err_count = err_count + 1;
    $display("unexpected at %0t: run did not finish", $time);
    test_done;
  end
endmodule
